// file: charger_cfg_defines.vh
// constants for the solar-tracking / thermal configuration register bank
// assumes byte address = 4 * register index on the register bus
`ifndef CHARGER_CFG_DEFINES_VH
`define CHARGER_CFG_DEFINES_VH

// ----------------------------------------
// register indexes and byte addresses
// ----------------------------------------
`define IDX_SOLAR_TRACKING 8'h15
`define IDX_THERMAL_LIMIT 8'h16
`define IDX_TEMP_DERATING 8'h17
`define ADDR_SOLAR_TRACKING (`IDX_SOLAR_TRACKING * 4)
`define ADDR_THERMAL_LIMIT (`IDX_THERMAL_LIMIT * 4)
`define ADDR_TEMP_DERATING (`IDX_TEMP_DERATING * 4)

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_SOLAR_TRACKING 8'hAA
`define RST_THERMAL_LIMIT 8'hC0
`define RST_TEMP_DERATING 8'h7A

// ----------------------------------------
// field positions
// ----------------------------------------
`define F_RATIO_MSB 7
`define F_RATIO_LSB 5
`define F_SETTLE_MSB 4
`define F_SETTLE_LSB 3
`define F_INTERVAL_MSB 2
`define F_INTERVAL_LSB 1
`define F_TRACK_EN 0
`define F_TREG_MSB 7
`define F_TREG_LSB 6
`define F_TSHUT_MSB 5
`define F_TSHUT_LSB 4
`define F_BUS_PD 3
`define F_ADP1_PD 2
`define F_ADP2_PD 1
`define F_BKUP_REQ 0
`define F_WARM_V_MSB 7
`define F_WARM_V_LSB 5
`define F_WARM_I_MSB 4
`define F_WARM_I_LSB 3
`define F_COOL_I_MSB 2
`define F_COOL_I_LSB 1
// bits of the thermal register that a watchdog expiry restores
`define WDOG_MASK_THERMAL 8'hF0
// writable bits of the derating register
`define WMASK_TEMP_DERATING 8'hFE

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define MS_IN_NS 1000000
`define CYCLES_PER_MS (`MS_IN_NS / `CLK_PERIOD_NS)
`define SETTLE_MS_0 21'h00032
`define SETTLE_MS_1 21'h0012C
`define SETTLE_MS_2 21'h007D0
`define SETTLE_MS_3 21'h01388
`define INTERVAL_MS_0 21'h07530
`define INTERVAL_MS_1 21'h1D4C0
`define INTERVAL_MS_2 21'h927C0
`define INTERVAL_MS_3 21'h1B7740

// ----------------------------------------
// bus answers
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: charger_mppt_thermal_cfg_regs.v
// solar-tracking, thermal-limit and temperature-derating register bank
// assumes an axi4-lite master and charger logic on the same clock
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
`include "charger_cfg_defines.vh"

module charger_mppt_thermal_cfg_regs
#(
   parameter ADDR_W = 8,
   parameter VOC_W = 16,
   parameter CYCLES_PER_MS = `CYCLES_PER_MS
)
(
   // clock, reset, enable
   input wire clk,
   input wire reset_n,
   input wire ce,
   // axi4-lite write address
   input wire [ADDR_W-1:0] awaddr,
   input wire awvalid,
   output reg awready_q,
   // axi4-lite write data
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output reg wready_q,
   // axi4-lite write response
   output reg [1:0] bresp_q,
   output reg bvalid_q,
   input wire bready,
   // axi4-lite read address
   input wire [ADDR_W-1:0] araddr,
   input wire arvalid,
   output reg arready_q,
   // axi4-lite read data
   output reg [31:0] rdata_q,
   output reg [1:0] rresp_q,
   output reg rvalid_q,
   input wire rready,
   // charger events
   input wire regReset,
   input wire watchdogExpiry,
   input wire backupMode,
   // open-circuit measurement
   input wire vocDone,
   input wire [VOC_W-1:0] vocValue,
   output reg switchStop_q,
   output reg vocSampleReq_q,
   output reg [VOC_W-1:0] inputVoltageTarget_q,
   // configuration outputs
   output reg solarTrackingEnable_q,
   output reg [1:0] thermalRegulationLimit_q,
   output reg [1:0] thermalShutdownLimit_q,
   output reg inputBusPulldownEnable_q,
   output reg adapter1PulldownEnable_q,
   output reg adapter2PulldownEnable_q,
   output reg backupEnableClear_q,
   output reg inputSwitchDriverDisableClear_q,
   output reg inputSwitch1DriverEnableSet_q,
   output reg [2:0] warmChargeVoltageSelect_q,
   output reg [1:0] warmChargeCurrentSelect_q,
   output reg [1:0] coolChargeCurrentSelect_q
);

   reg [7:0] solarTracking_q;
   reg [7:0] thermalLimit_q;
   reg [7:0] tempDerating_q;
   reg [ADDR_W-1:0] wAddr_q;
   reg [7:0] wByte_q;
   reg wByteEn_q;
   reg haveAddr_q;
   reg haveData_q;
   reg [7:0] rdByte;
   reg rdHit;
   wire doWrite;
   wire wrSolar;
   wire wrThermal;
   wire wrDerating;
   wire wrHit;
   wire seqStop;
   wire seqSample;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function [1:0] decode;
      input [ADDR_W-1:0] addr;
      begin
         if (addr == `ADDR_SOLAR_TRACKING)
            decode = 2'h1;
         else if (addr == `ADDR_THERMAL_LIMIT)
            decode = 2'h2;
         else if (addr == `ADDR_TEMP_DERATING)
            decode = 2'h3;
         else
            decode = 2'h0;
      end
   endfunction

   // ratio codes 0..7 select (9 + code) / 16
   function [VOC_W-1:0] scaleVoc;
      input [VOC_W-1:0] voc;
      input [2:0] code;
      reg [VOC_W+4:0] prod;
      begin
         prod = {5'h00, voc} * {{VOC_W{1'b0}}, {2'h0, code} + 5'h09};
         scaleVoc = prod[VOC_W+3:4];
      end
   endfunction

   assign doWrite = haveAddr_q && haveData_q && !bvalid_q;
   assign wrHit = (decode(wAddr_q) != 2'h0);
   assign wrSolar = doWrite && wByteEn_q && (decode(wAddr_q) == 2'h1);
   assign wrThermal = doWrite && wByteEn_q && (decode(wAddr_q) == 2'h2);
   assign wrDerating = doWrite && wByteEn_q && (decode(wAddr_q) == 2'h3);

   // ----------------------------------------
   // write channel
   // ----------------------------------------
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         haveAddr_q <= 1'b0;
         haveData_q <= 1'b0;
         wAddr_q <= {ADDR_W{1'b0}};
         wByte_q <= 8'h00;
         wByteEn_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end
      else if (ce)
      begin
         if (awvalid && awready_q)
         begin
            wAddr_q <= awaddr;
            haveAddr_q <= 1'b1;
            awready_q <= 1'b0;
         end
         if (wvalid && wready_q)
         begin
            wByte_q <= wdata[7:0];
            wByteEn_q <= wstrb[0];
            haveData_q <= 1'b1;
            wready_q <= 1'b0;
         end
         if (doWrite)
         begin
            bvalid_q <= 1'b1;
            bresp_q <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
            haveAddr_q <= 1'b0;
            haveData_q <= 1'b0;
         end
         if (bvalid_q && bready)
         begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   always @*
   begin
      rdByte = 8'h00;
      rdHit = 1'b1;
      case (decode(araddr))
         2'h1: rdByte = solarTracking_q;
         2'h2: rdByte = thermalLimit_q;
         2'h3: rdByte = tempDerating_q & `WMASK_TEMP_DERATING;
         default: rdHit = 1'b0;
      endcase
   end

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `RESP_OKAY;
      end
      else if (ce)
      begin
         if (arvalid && arready_q)
         begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {24'h000000, rdByte};
            rresp_q <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (rvalid_q && rready)
         begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         solarTracking_q <= `RST_SOLAR_TRACKING;
         thermalLimit_q <= `RST_THERMAL_LIMIT;
         tempDerating_q <= `RST_TEMP_DERATING;
         backupEnableClear_q <= 1'b0;
         inputSwitchDriverDisableClear_q <= 1'b0;
         inputSwitch1DriverEnableSet_q <= 1'b0;
      end
      else if (ce)
      begin
         backupEnableClear_q <= 1'b0;
         inputSwitchDriverDisableClear_q <= 1'b0;
         inputSwitch1DriverEnableSet_q <= 1'b0;
         if (regReset)
         begin
            solarTracking_q <= `RST_SOLAR_TRACKING;
            thermalLimit_q <= `RST_THERMAL_LIMIT;
            tempDerating_q <= `RST_TEMP_DERATING;
         end
         else
         begin
            if (wrSolar)
               solarTracking_q <= wByte_q;
            if (watchdogExpiry)
            begin
               // watchdog restores only the thermal limits and the derating fields
               thermalLimit_q <= (`RST_THERMAL_LIMIT & `WDOG_MASK_THERMAL)
                  | (thermalLimit_q & ~`WDOG_MASK_THERMAL);
               tempDerating_q <= `RST_TEMP_DERATING;
            end
            else
            begin
               if (wrThermal)
               begin
                  if (wByte_q[`F_BKUP_REQ] && backupMode)
                  begin
                     // request acts at once and the bit returns to idle
                     thermalLimit_q <= {wByte_q[7:1], 1'b0};
                     backupEnableClear_q <= 1'b1;
                     inputSwitchDriverDisableClear_q <= 1'b1;
                     inputSwitch1DriverEnableSet_q <= 1'b1;
                  end
                  else
                     thermalLimit_q <= wByte_q;
               end
               if (wrDerating)
                  tempDerating_q <= wByte_q & `WMASK_TEMP_DERATING;
            end
         end
      end
   end

   // ----------------------------------------
   // decoded configuration outputs
   // ----------------------------------------
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         solarTrackingEnable_q <= 1'b0;
         thermalRegulationLimit_q <= 2'h3;
         thermalShutdownLimit_q <= 2'h0;
         inputBusPulldownEnable_q <= 1'b0;
         adapter1PulldownEnable_q <= 1'b0;
         adapter2PulldownEnable_q <= 1'b0;
         warmChargeVoltageSelect_q <= 3'h3;
         warmChargeCurrentSelect_q <= 2'h3;
         coolChargeCurrentSelect_q <= 2'h1;
      end
      else if (ce)
      begin
         solarTrackingEnable_q <= solarTracking_q[`F_TRACK_EN];
         thermalRegulationLimit_q <= thermalLimit_q[`F_TREG_MSB:`F_TREG_LSB];
         thermalShutdownLimit_q <= thermalLimit_q[`F_TSHUT_MSB:`F_TSHUT_LSB];
         inputBusPulldownEnable_q <= thermalLimit_q[`F_BUS_PD];
         adapter1PulldownEnable_q <= thermalLimit_q[`F_ADP1_PD];
         adapter2PulldownEnable_q <= thermalLimit_q[`F_ADP2_PD];
         warmChargeVoltageSelect_q <= tempDerating_q[`F_WARM_V_MSB:`F_WARM_V_LSB];
         warmChargeCurrentSelect_q <= tempDerating_q[`F_WARM_I_MSB:`F_WARM_I_LSB];
         coolChargeCurrentSelect_q <= tempDerating_q[`F_COOL_I_MSB:`F_COOL_I_LSB];
      end
   end

   // ----------------------------------------
   // open-circuit tracking
   // ----------------------------------------
   solar_voc_sequencer
   #(
      .CYCLES_PER_MS(CYCLES_PER_MS)
   )
   sequencer
   (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .enable(solarTracking_q[`F_TRACK_EN]),
      .settleSel(solarTracking_q[`F_SETTLE_MSB:`F_SETTLE_LSB]),
      .intervalSel(solarTracking_q[`F_INTERVAL_MSB:`F_INTERVAL_LSB]),
      .measDone(vocDone),
      .switchStop_q(seqStop),
      .sampleReq_q(seqSample)
   );

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         switchStop_q <= 1'b0;
         vocSampleReq_q <= 1'b0;
         inputVoltageTarget_q <= {VOC_W{1'b0}};
      end
      else if (ce)
      begin
         switchStop_q <= seqStop;
         vocSampleReq_q <= seqSample;
         if (vocDone && seqStop)
            inputVoltageTarget_q <= scaleVoc(vocValue, solarTracking_q[`F_RATIO_MSB:`F_RATIO_LSB]);
      end
   end

endmodule

// file: charger_mppt_thermal_cfg_regs_bench.sv
// self-checking bench for the solar-tracking / thermal register bank
// assumes design and checker compiled first; ce dropped only in its own test
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin failures++; \
   $display("BAD %s expected %h seen %h", nm, e, g); end end
module charger_mppt_thermal_cfg_regs_bench;
   // ----------------
   // signals
   // ----------------
   logic clk = 1'b0, reset_n = 1'b0, ce = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic regReset = 1'b0, watchdogExpiry = 1'b0, backupMode = 1'b0, vocDone = 1'b0;
   logic [15:0] vocValue = 16'h0;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, switchStop_q, vocSampleReq_q;
   logic solarTrackingEnable_q, inputBusPulldownEnable_q, adapter1PulldownEnable_q, adapter2PulldownEnable_q;
   logic backupEnableClear_q, inputSwitchDriverDisableClear_q, inputSwitch1DriverEnableSet_q;
   logic [1:0] bresp_q, rresp_q, thermalRegulationLimit_q, thermalShutdownLimit_q;
   logic [1:0] warmChargeCurrentSelect_q, coolChargeCurrentSelect_q;
   logic [2:0] warmChargeVoltageSelect_q, ratio;
   logic [31:0] rdata_q, seed = 32'hE1831A5B;
   logic [15:0] inputVoltageTarget_q;
   logic [7:0] ev;
   int failures = 0, checksDone = 0, pulseCount = 0, i, n;

   charger_mppt_thermal_cfg_regs #(.CYCLES_PER_MS(1)) dut (.*);

   always #2 clk = ~clk;
   always @(posedge clk)
   begin
      if (backupEnableClear_q && inputSwitchDriverDisableClear_q && inputSwitch1DriverEnableSet_q)
         pulseCount++;
   end
   // ----------------
   // helpers
   // ----------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] target(input logic [15:0] v, input logic [2:0] r);
      return 16'((32'(v) * (9 + r)) >> 4);
   endfunction
   function automatic logic [7:0] outs(input int k);
      if (k == 0)
         return {7'h0, solarTrackingEnable_q};
      if (k == 1)
         return {thermalRegulationLimit_q, thermalShutdownLimit_q, inputBusPulldownEnable_q,
            adapter1PulldownEnable_q, adapter2PulldownEnable_q, 1'b0};
      return {warmChargeVoltageSelect_q, warmChargeCurrentSelect_q, coolChargeCurrentSelect_q, 1'b0};
   endfunction
   task automatic give_verdict;
      $display("checks %0d failures %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic bound_hit(input int k, input int lim);
      if (k >= lim)
      begin
         failures++;
         $display("BAD wait expected answer seen none");
         give_verdict;
      end
   endtask
   task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clk);
         if (awvalid && awready_q)
            awvalid <= 1'b0;
         if (wvalid && wready_q)
            wvalid <= 1'b0;
         if (bvalid_q)
         begin
            `CHK("bresp", er, bresp_q)
            bready <= 1'b0;
            break;
         end
      end
      bound_hit(k, 50);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      int k;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clk);
         if (arvalid && arready_q)
            arvalid <= 1'b0;
         if (rvalid_q)
         begin
            `CHK("rdata", {24'h0, e}, rdata_q)
            `CHK("rresp", er, rresp_q)
            rready <= 1'b0;
            break;
         end
      end
      bound_hit(k, 50);
   endtask
   task automatic wait_sig(input int w, input int lim, output int k);
      for (k = 0; k < lim; k++)
      begin
         @(posedge clk);
         if ((w == 0 ? switchStop_q : vocSampleReq_q) === 1'b1)
            break;
      end
      bound_hit(k, lim);
   endtask
   task automatic event_pulse(input int w);
      if (w == 0)
         watchdogExpiry <= 1'b1;
      else
         regReset <= 1'b1;
      @(posedge clk);
      watchdogExpiry <= 1'b0;
      regReset <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic measure(input logic [1:0] settle, input int ms);
      int k;
      seed = lfsr(seed);
      ratio = seed[7:5];
      wr_chk(8'h54, {24'h0, ratio, settle, 3'b001}, 2'h0);
      wait_sig(0, 31000, k);
      `CHK("interval", 1'b1, k >= 29990 && k <= 30010)
      wait_sig(1, 6000, k);
      `CHK("settle", 1'b1, k >= ms - 1 && k <= ms + 3)
      vocValue <= seed[31:16];
      vocDone <= 1'b1;
      @(posedge clk);
      vocDone <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK("target", target(seed[31:16], ratio), inputVoltageTarget_q)
      $display("test measurement done");
   endtask
   // ----------------
   // sequence
   // ----------------
   initial
   begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd_chk(8'h54, 8'hAA, 2'h0);
      rd_chk(8'h58, 8'hC0, 2'h0);
      rd_chk(8'h5C, 8'h7A, 2'h0);
      `CHK("resetOuts", 17'h0C07A, {solarTrackingEnable_q, outs(1), outs(2)})
      $display("test reset values done");
      for (i = 0; i < 12; i++)
      begin
         seed = lfsr(seed);
         n = i % 3;
         ev = seed[7:0] & (n == 2 ? 8'hFE : 8'hFF);
         wr_chk(8'h54 + 8'(4 * n), seed, 2'h0);
         repeat (2) @(posedge clk);
         `CHK("fields", ev & (n == 0 ? 8'h01 : 8'hFE), outs(n))
         rd_chk(8'h54 + 8'(4 * n), ev, 2'h0);
      end
      $display("test random access done");
      for (i = 0; i < 2; i++)
      begin
         wr_chk(i ? 8'h60 : 8'h50, 32'hFF, 2'h2);
         rd_chk(i ? 8'h60 : 8'h50, 8'h00, 2'h2);
      end
      $display("test unmapped done");
      wr_chk(8'h58, 32'h3E, 2'h0);
      wr_chk(8'h5C, 32'h80, 2'h0);
      event_pulse(0);
      rd_chk(8'h58, 8'hCE, 2'h0);
      rd_chk(8'h5C, 8'h7A, 2'h0);
      event_pulse(1);
      rd_chk(8'h58, 8'hC0, 2'h0);
      rd_chk(8'h54, 8'hAA, 2'h0);
      $display("test restore done");
      backupMode <= 1'b1;
      wr_chk(8'h58, 32'hC1, 2'h0);
      backupMode <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("switchPulses", 1, pulseCount)
      rd_chk(8'h58, 8'hC0, 2'h0);
      wr_chk(8'h58, 32'hC1, 2'h0);
      repeat (3) @(posedge clk);
      `CHK("switchPulses", 1, pulseCount)
      rd_chk(8'h58, 8'hC1, 2'h0);
      $display("test backup done");
      wr_chk(8'h5C, 32'h80, 2'h0);
      ce <= 1'b0;
      regReset <= 1'b1;
      repeat (3) @(posedge clk);
      regReset <= 1'b0;
      ce <= 1'b1;
      rd_chk(8'h5C, 8'h80, 2'h0);
      $display("test clock enable done");
      measure(2'h0, 50);
      measure(2'h1, 300);
      give_verdict;
   end
endmodule

// file: charger_mppt_thermal_cfg_regs_chk.sv
// assertions for the solar-tracking / thermal register bank
// assumes one clock domain; checks pause while ce is low
`timescale 1ns/1ns
module charger_mppt_thermal_cfg_regs_chk
(
   // clock and reset
   input wire clk,
   input wire reset_n,
   input wire ce,
   // register bus
   input wire awvalid,
   input wire awready_q,
   input wire wvalid,
   input wire wready_q,
   input wire bvalid_q,
   input wire arvalid,
   input wire arready_q,
   input wire [31:0] rdata_q,
   input wire rvalid_q,
   input wire rready,
   // charger side
   input wire regReset,
   input wire watchdogExpiry,
   input wire backupMode,
   input wire vocDone,
   input wire switchStop_q,
   input wire vocSampleReq_q,
   input wire solarTrackingEnable_q,
   input wire [1:0] thermalRegulationLimit_q,
   input wire [1:0] thermalShutdownLimit_q,
   input wire inputBusPulldownEnable_q,
   input wire [2:0] warmChargeVoltageSelect_q,
   input wire [1:0] warmChargeCurrentSelect_q,
   input wire [1:0] coolChargeCurrentSelect_q,
   input wire backupEnableClear_q,
   input wire inputSwitchDriverDisableClear_q,
   input wire inputSwitch1DriverEnableSet_q
);
   // ----------------
   // properties
   // ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n || !ce);
   sequence s_wr_taken;
      awvalid && awready_q && wvalid && wready_q;
   endsequence
   sequence s_rd_taken;
      arvalid && arready_q;
   endsequence
   sequence s_temp_defaults;
      thermalRegulationLimit_q == 2'h3 && thermalShutdownLimit_q == 2'h0 && warmChargeVoltageSelect_q == 3'h3
      && warmChargeCurrentSelect_q == 2'h3 && coolChargeCurrentSelect_q == 2'h1;
   endsequence
   property p_wr_answer;
      s_wr_taken |-> ##[1:2] bvalid_q;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
   property p_rd_answer;
      s_rd_taken |=> rvalid_q && rdata_q[31:8] == 24'h0;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_rd_hold;
      rvalid_q && !rready |=> rvalid_q && $stable(rdata_q);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
   property p_sample_in_stop;
      vocSampleReq_q |-> switchStop_q ##1 !vocSampleReq_q;
   endproperty
   a_sample_in_stop: assert property (p_sample_in_stop) else $error("sample outside stop");
   property p_idle_off;
      !solarTrackingEnable_q [*3] |-> !switchStop_q && !vocSampleReq_q;
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("measuring while disabled");
   property p_stop_ends;
      vocDone && switchStop_q |-> ##[1:2] !switchStop_q;
   endproperty
   a_stop_ends: assert property (p_stop_ends) else $error("stop held after done");
   property p_switch_trio;
      backupEnableClear_q |-> inputSwitchDriverDisableClear_q && inputSwitch1DriverEnableSet_q
         && $rose(bvalid_q) ##1 !backupEnableClear_q;
   endproperty
   a_switch_trio: assert property (p_switch_trio) else $error("switch pulses broken");
   property p_switch_mode;
      !backupMode [*4] |-> !backupEnableClear_q;
   endproperty
   a_switch_mode: assert property (p_switch_mode) else $error("switch pulse outside backup");
   property p_reg_reset;
      regReset |-> ##2 s_temp_defaults ##0 (!solarTrackingEnable_q && !inputBusPulldownEnable_q);
   endproperty
   a_reg_reset: assert property (p_reg_reset) else $error("register reset missed");
   property p_wdog;
      watchdogExpiry |-> ##2 s_temp_defaults;
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog restore missed");
endmodule

bind charger_mppt_thermal_cfg_regs charger_mppt_thermal_cfg_regs_chk chk (.*);

// file: solar_voc_sequencer.v
// open-circuit measurement sequencer: interval timer, settle delay, sample strobe
// assumes measDone is a one-cycle pulse from converter logic on the same clock
`timescale 1ns/1ns
`include "charger_cfg_defines.vh"

module solar_voc_sequencer
#(
   parameter CYCLES_PER_MS = `CYCLES_PER_MS
)
(
   // clock and reset
   input wire clk,
   input wire reset_n,
   input wire ce,
   // settings
   input wire enable,
   input wire [1:0] settleSel,
   input wire [1:0] intervalSel,
   // converter side
   input wire measDone,
   output reg switchStop_q,
   output reg sampleReq_q
);

   localparam ST_WAIT = 2'h0;
   localparam ST_SETTLE = 2'h1;
   localparam ST_SAMPLE = 2'h2;

   reg [1:0] state_q;
   reg [31:0] tickCnt_q;
   reg [20:0] msCnt_q;
   wire msTick;

   // ----------------------------------------
   // table lookups
   // ----------------------------------------
   function [20:0] settleMs;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: settleMs = `SETTLE_MS_0;
            2'h1: settleMs = `SETTLE_MS_1;
            2'h2: settleMs = `SETTLE_MS_2;
            default: settleMs = `SETTLE_MS_3;
         endcase
      end
   endfunction

   function [20:0] intervalMs;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: intervalMs = `INTERVAL_MS_0;
            2'h1: intervalMs = `INTERVAL_MS_1;
            2'h2: intervalMs = `INTERVAL_MS_2;
            default: intervalMs = `INTERVAL_MS_3;
         endcase
      end
   endfunction

   assign msTick = (tickCnt_q == CYCLES_PER_MS - 1);

   // ----------------------------------------
   // millisecond prescaler and sequence
   // ----------------------------------------
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= ST_WAIT;
         tickCnt_q <= 32'h0;
         msCnt_q <= 21'h0;
         switchStop_q <= 1'b0;
         sampleReq_q <= 1'b0;
      end
      else if (ce)
      begin
         sampleReq_q <= 1'b0;
         tickCnt_q <= msTick ? 32'h0 : tickCnt_q + 32'h1;
         if (!enable)
         begin
            // measuring runs only while tracking is enabled
            state_q <= ST_WAIT;
            msCnt_q <= 21'h0;
            switchStop_q <= 1'b0;
         end
         else
         begin
            case (state_q)
               ST_WAIT:
               begin
                  if (msTick)
                  begin
                     if (msCnt_q + 21'h1 >= intervalMs(intervalSel))
                     begin
                        // repeat at the selected interval
                        state_q <= ST_SETTLE;
                        msCnt_q <= 21'h0;
                        switchStop_q <= 1'b1;
                     end
                     else
                        msCnt_q <= msCnt_q + 21'h1;
                  end
               end
               ST_SETTLE:
               begin
                  if (msTick)
                  begin
                     if (msCnt_q + 21'h1 >= settleMs(settleSel))
                     begin
                        // settle delay elapsed before sampling
                        state_q <= ST_SAMPLE;
                        msCnt_q <= 21'h0;
                        sampleReq_q <= 1'b1;
                     end
                     else
                        msCnt_q <= msCnt_q + 21'h1;
                  end
               end
               ST_SAMPLE:
               begin
                  if (measDone)
                  begin
                     state_q <= ST_WAIT;
                     switchStop_q <= 1'b0;
                  end
               end
               default:
               begin
                  state_q <= ST_WAIT;
                  switchStop_q <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule
